//--- pcd_top.sv
// Pin change detect: per-pin edge flags, summary flag, interrupt and wake request.
// Assumes pins are asynchronous to aclk and the core drives sleep_mode on aclk.
//
// Summary of operation
// - Every pin of every port can flag change
// - Master enable clear: flags set, no interrupt
// - Rising detector gated by its enable bit
// - Falling detector gated by its enable bit
// - Both enables set: either edge detected
// - Enabled edge sets flag; irq if enabled
// - Read-only summary flag is OR of flags
// - Software clears flag bits by writing zero
// - Edge during flag write keeps flag set
// - Change event wakes from sleep if enabled
// - Flags updated before wake request rises
// - Port A rising enable, eight bits, reset zero
// - Port A falling enable, eight bits, reset zero
// - Cleared enable blocks flag and summary setting
// - Per-port eight-bit flag register, resets zero
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`include "pcd_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module pcd_top import pcd_pkg::*; #(
  parameter int NUM_PORTS = 5,
  parameter int PINS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_PORTS*PINS-1:0] pin_in,
  input wire logic sleep_mode,
  output logic irq_req,
  output logic wake_req,
  input wire logic [`PCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NPIN = NUM_PORTS * PINS;

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] sync3_r;
  logic [NPIN-1:0] level_r;
  logic [NPIN-1:0] rise_en_r;
  logic [NPIN-1:0] fall_en_r;
  logic [NPIN-1:0] flag_r;
  logic [NPIN-1:0] flag_nxt;
  logic [NPIN-1:0] edge_set;
  logic master_en_r;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic agree;
      logic rise;
      logic fall;
      // A change counts only once stages two and three agree, filtering metastable glitches
      assign agree = (sync2_r[gi] == sync3_r[gi]);
      assign rise = agree & sync3_r[gi] & ~level_r[gi] & rise_en_r[gi];
      assign fall = agree & ~sync3_r[gi] & level_r[gi] & fall_en_r[gi];
      assign edge_set[gi] = rise | fall;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          level_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (agree) begin
            level_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Address decode
  function automatic logic dec_ok(input logic [`PCD_ADDR_W-1:0] a);
    logic [3:0] pg;
    pg = a[7:4];
    if (a == `PCD_ADDR_CTRL) begin
      dec_ok = 1'b1;
    end else if (pg >= `PCD_PORT_FIRST && (32'(pg) - 32'(`PCD_PORT_FIRST)) < 32'(NUM_PORTS)) begin
      dec_ok = (a[3:0] == `PCD_OFS_RISE) || (a[3:0] == `PCD_OFS_FALL) ||
               (a[3:0] == `PCD_OFS_FLAG);
    end else begin
      dec_ok = 1'b0;
    end
  endfunction : dec_ok

  function automatic pcd_sel_t dec_sel(input logic [`PCD_ADDR_W-1:0] a);
    if (a == `PCD_ADDR_CTRL) begin
      dec_sel = PCD_SEL_CTRL;
    end else if (a[3:0] == `PCD_OFS_RISE) begin
      dec_sel = PCD_SEL_RISE;
    end else if (a[3:0] == `PCD_OFS_FALL) begin
      dec_sel = PCD_SEL_FALL;
    end else begin
      dec_sel = PCD_SEL_FLAG;
    end
  endfunction : dec_sel

  function automatic int dec_port(input logic [`PCD_ADDR_W-1:0] a);
    dec_port = int'(a[7:4]) - int'(`PCD_PORT_FIRST);
  endfunction : dec_port

  // ==========================================================
  // Write channel: address and data taken in either order
  logic aw_full_r;
  logic w_full_r;
  logic [`PCD_ADDR_W-1:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic wr_go;
  logic wr_ok;
  pcd_sel_t wr_sel;
  int wr_port;

  assign wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_ok = dec_ok(waddr_r);
  assign wr_sel = dec_sel(waddr_r);
  assign wr_port = dec_port(waddr_r);

  // Ready stays low until the answer is taken, so only one write is ever in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      waddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      waddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wbyte_r <= `PCD_RST_BYTE;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      wbyte_r <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  // Response follows both halves; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCD_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control and enable registers
  logic wr_byte;
  assign wr_byte = wr_go & wr_ok & wstrb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_en_r <= 1'b0;
    end else if (wr_byte && wr_sel == PCD_SEL_CTRL) begin
      master_en_r <= wbyte_r[`PCD_CTRL_MEN_BIT];
    end
  end

  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rise_en_r[gi*PINS +: PINS] <= `PCD_RST_BYTE;
          fall_en_r[gi*PINS +: PINS] <= `PCD_RST_BYTE;
        end else if (wr_byte && wr_port == gi) begin
          if (wr_sel == PCD_SEL_RISE) begin
            rise_en_r[gi*PINS +: PINS] <= wbyte_r[PINS-1:0];
          end
          if (wr_sel == PCD_SEL_FALL) begin
            fall_en_r[gi*PINS +: PINS] <= wbyte_r[PINS-1:0];
          end
        end
      end

      // Hardware set wins over any written value so a racing edge is never lost
      always_comb begin
        flag_nxt[gi*PINS +: PINS] = flag_r[gi*PINS +: PINS];
        if (wr_byte && wr_port == gi && wr_sel == PCD_SEL_FLAG) begin
          flag_nxt[gi*PINS +: PINS] = wbyte_r[PINS-1:0];
        end
        flag_nxt[gi*PINS +: PINS] = flag_nxt[gi*PINS +: PINS] |
                                    edge_set[gi*PINS +: PINS];
      end
    end
  endgenerate

  // ==========================================================
  // Flags, interrupt and wake
  logic summary;
  assign summary = |flag_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Requests follow the flags by one cycle, so flags are already visible on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= master_en_r & summary;
    end
  end

  // Wake is a level; the core decides when to act on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep_mode & master_en_r & summary;
    end
  end

  // ==========================================================
  // Read channel: one read at a time, answer one cycle after the address
  logic [7:0] rd_byte;
  pcd_sel_t rd_sel;
  int rd_port;

  assign rd_sel = dec_sel(s_axi_araddr);
  assign rd_port = dec_port(s_axi_araddr);

  always_comb begin
    rd_byte = `PCD_RST_BYTE;
    if (rd_sel == PCD_SEL_CTRL) begin
      rd_byte[`PCD_CTRL_MEN_BIT] = master_en_r;
      rd_byte[`PCD_CTRL_SUM_BIT] = summary;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (rd_port == p) begin
          case (rd_sel)
            PCD_SEL_RISE: rd_byte = rise_en_r[p*PINS +: PINS];
            PCD_SEL_FALL: rd_byte = fall_en_r[p*PINS +: PINS];
            PCD_SEL_FLAG: rd_byte = flag_r[p*PINS +: PINS];
            default: rd_byte = `PCD_RST_BYTE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and code are captured once at the take and then stand untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= `PCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= dec_ok(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp <= dec_ok(s_axi_araddr) ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
    end
  end

  // Protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

endmodule : pcd_top

`default_nettype wire

//--- pcd_regs.svh
// Register map and constants for the pin change detect block.
// Assumes a 32-bit AXI4-Lite slave with byte addresses; included by bare name.
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH

// ==========================================================
// Address map
`define PCD_ADDR_W 8
`define PCD_ADDR_CTRL 8'h00
`define PCD_PORT_FIRST 4'h1
`define PCD_OFS_RISE 4'h0
`define PCD_OFS_FALL 4'h4
`define PCD_OFS_FLAG 4'h8

// ==========================================================
// Control register fields
`define PCD_CTRL_MEN_BIT 0
`define PCD_CTRL_SUM_BIT 1

// ==========================================================
// Reset values and bus answers
`define PCD_RST_BYTE 8'h00
`define PCD_RESP_OKAY 2'h0
`define PCD_RESP_SLVERR 2'h2
`define PCD_SYNC_RST 3'h0

`endif

//--- pcd_pkg.sv
// Types shared by the pin change detect block.
// Assumes pcd_regs.svh supplies the numeric map.
package pcd_pkg;

  // ==========================================================
  // Register select decoded from an address
  typedef enum logic [3:0] {
    PCD_SEL_CTRL = 4'b0001,
    PCD_SEL_RISE = 4'b0010,
    PCD_SEL_FALL = 4'b0100,
    PCD_SEL_FLAG = 4'b1000
  } pcd_sel_t;

  typedef logic [1:0] pcd_resp_t;
  typedef logic [7:0] pcd_byte_t;

endpackage : pcd_pkg

//--- pcd_asserts.sv
// Checker for the pin change detect block, bound to pcd_top.
// Assumes the top's ports only; flags are seen through irq_req.
`timescale 1ns/100ps
`default_nettype none
module pcd_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_mode,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wake_gate_a: assert property (wake_req |-> irq_req && $past(sleep_mode))
    else $error("wake request without irq or sleep");
  rst_quiet_a: assert property ($rose(aresetn) |-> !irq_req && !wake_req)
    else $error("request active after reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  rd_turn_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  wr_turn_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready ##[0:2] s_axi_bvalid) else $error("write answer late");
  rd_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  irq_drop_a: assert property ($fell(irq_req) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("irq fell without write");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
endmodule : pcd_asserts
bind pcd_top pcd_asserts u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .sleep_mode(sleep_mode),
  .irq_req(irq_req),
  .wake_req(wake_req),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

//--- pcd_pin_model.sv
// Far side: port pins and the core's sleep state.
// Assumes the bench sets wanted levels; they reach the block at aclk edges.
`timescale 1ns/100ps
`default_nettype none
module pcd_pin_model (
  input wire logic aclk,
  input wire logic [39:0] lvl,
  input wire logic slp,
  output logic [39:0] pin_in = 40'h0,
  output logic sleep_mode = 1'b0
);
  // ==========================================================
  // Levels are held for many cycles, well above the pulse floor
  always @(posedge aclk) begin
    pin_in <= lvl;
    sleep_mode <= slp;
  end
endmodule : pcd_pin_model
`default_nettype wire

//--- tb.sv
// Testbench for pcd_top: register bus master, pin stimulus, queue checks.
// Assumes port p registers sit at byte address 0x10*(p+1), control at 0x00.
`include "pcd_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk = 0, aresetn = 0, sleep_mode, irq_req, wake_req, slp = 0;
  logic [39:0] pin_in, lvl = 40'h0;
  logic [`PCD_ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h0000afa3;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [63:0] r;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  pcd_top i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .sleep_mode(sleep_mode),
    .irq_req(irq_req),
    .wake_req(wake_req),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  pcd_pin_model i_pins (
    .aclk(aclk),
    .lvl(lvl),
    .slp(slp),
    .pin_in(pin_in),
    .sleep_mode(sleep_mode)
  );
  initial forever #5 aclk = ~aclk;
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    cmp({32'h0, g}, {32'h0, e});
  endtask : cmp_b
  task automatic cmp_lvl(input logic [1:0] g, input logic [1:0] e);
    cmp({32'h0, g}, {32'h0, e});
  endtask : cmp_lvl
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
    bq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Channels are released on their own ready, in either order
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
    rq.push_back({e, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Result watcher and hang guard
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_b(s_axi_bresp, bq.pop_front());
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'hf0, 8'h00, 2'h2);
    wr(8'hf0, 8'h5a, 2'h2);
    r[31:0] = xs();
    wr(8'h10, r[7:0]);
    wr(8'h14, ~r[7:0]);
    // A write with its low strobe clear must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(8'h10, ~r[7:0]);
    s_axi_wstrb <= 4'hf;
    rd(8'h10, r[7:0]);
    rd(8'h14, ~r[7:0]);
    wr(8'h10, 8'h0f);
    wr(8'h14, 8'h3c);
    lvl[7:0] <= 8'hff;
    repeat (8) @(posedge aclk);
    rd(8'h18, 8'h0f);
    rd(8'h00, 8'h02);
    @(negedge aclk);
    cmp_lvl({irq_req, wake_req}, 2'b00);
    lvl[7:0] <= 8'h00;
    repeat (8) @(posedge aclk);
    rd(8'h18, 8'h3f);
    wr(8'h00, 8'h01);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    cmp_lvl({irq_req, wake_req}, 2'b10);
    slp <= 1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    cmp_lvl({irq_req, wake_req}, 2'b11);
    // Clearing with a mask: flags read AND the inverse of the known changes
    wr(8'h18, 8'h3f & 8'hc0);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    cmp_lvl({irq_req, wake_req}, 2'b00);
    rd(8'h00, 8'h01);
    // Edge lands in the very cycle the clearing write commits: the set must win
    lvl[0] <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h01);
    lvl[0] <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(8'h18, 8'h01 & 8'hfe);
    rd(8'h18, 8'h00);
    slp <= 0;
    for (int p = 0; p < 5; p++) wr(8'(8'h10 * (p + 1)), 8'hff);
    r = {xs(), xs()};
    lvl <= r[39:0];
    repeat (8) @(posedge aclk);
    for (int p = 0; p < 5; p++) rd(8'(8'h10 * (p + 1) + 8'h08), r[p * 8 +: 8]);
    // Reset in mid-run must clear enables and flags while pins hold the random levels
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'h00);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    cmp_lvl({irq_req, wake_req}, 2'b00);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
